// >>> hdl/wdt_regs.svh
// register offsets, field positions, reset values and refresh bytes of the watchdog
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH
`define WDT_OFS_REFRESH 12'h000
`define WDT_OFS_CTRL 12'h004
`define WDT_OFS_STATUS 12'h008
`define WDT_OFS_RSTCTRL 12'h00C
`define WDT_OFS_MODE 12'h010
`define WDT_RF_FIRST 8'h00
`define WDT_RF_SECOND 8'hFF
`define WDT_CTRL_TO_LSB 0
`define WDT_CTRL_CKS_LSB 4
`define WDT_CTRL_WEND_LSB 8
`define WDT_CTRL_WSTART_LSB 12
`define WDT_CTRL_RESET 32'h0000_3353
`define WDT_ST_UNDF_BIT 14
`define WDT_ST_REFE_BIT 15
`define WDT_ST_RUN_BIT 16
`define WDT_RC_RESET 32'h0000_0080
`define WDT_RC_RSTE_BIT 7
`define WDT_RC_NMI_BIT 0
`define WDT_MODE_RESET 32'h0000_0000
`define WDT_MODE_AUTO_BIT 0
`define WDT_MODE_LPEN_BIT 1
`endif

// >>> hdl/wdt_pkg.sv
// types shared by the watchdog design files
package wdt_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_STOP = 3'b100
  } wdt_state_t;
endpackage

// >>> hdl/wdt_tick_if.sv
// count-clock enable carried from the prescaler to the counter core
`timescale 1ns/1ns
`default_nettype none
interface wdt_tick_if;
  logic [2:0] sel;
  logic clear;
  logic tick;
  modport src (input sel, input clear, output tick);
  modport dst (output sel, output clear, input tick);
endinterface
`default_nettype wire

// >>> hdl/wdt_prescaler.sv
// prescaler: one-cycle count enable at pclk divided by the selected ratio
`timescale 1ns/1ns
`default_nettype none
`include "wdt_regs.svh"
module wdt_prescaler #(
  parameter int DIV_W = 13
) (
  input wire logic pclk,
  input wire logic presetn,
  wdt_tick_if.src tk
);
  initial begin
    if (DIV_W < 13) $error("prescaler too narrow for divide by 8192");
  end
  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] lim;
  // division ratio 4,64,128,512,2048,8192; codes 6,7 fall back to 8192 [R1]
  always_comb begin
    case (tk.sel)
      3'h0: lim = DIV_W'(4 - 1);
      3'h1: lim = DIV_W'(64 - 1);
      3'h2: lim = DIV_W'(128 - 1);
      3'h3: lim = DIV_W'(512 - 1);
      3'h4: lim = DIV_W'(2048 - 1);
      default: lim = DIV_W'(8192 - 1);
    endcase
  end
  // free divider, restarted on refresh so every window starts aligned [R1]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (tk.clear || cnt_r >= lim) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + DIV_W'(1);
    end
  end
  assign tk.tick = (cnt_r >= lim) && !tk.clear;
endmodule
`default_nettype wire

// >>> hdl/wdt_apb_regs.sv
// apb slave decoding the watchdog register map
`timescale 1ns/1ns
`default_nettype none
`include "wdt_regs.svh"
module wdt_apb_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] status_in,
  output logic [31:0] rdata_nxt,
  output logic wr_refresh,
  output logic wr_ctrl,
  output logic wr_rstctrl,
  output logic wr_mode,
  output logic wr_status,
  output logic rd_err,
  input wire logic [31:0] ctrl_in,
  input wire logic [31:0] rc_in,
  input wire logic [31:0] mode_in
);
  logic acc;
  assign acc = psel && penable;
  // zero-wait slave: writes strobe on the access cycle
  assign wr_refresh = acc && pwrite && paddr == `WDT_OFS_REFRESH;
  assign wr_ctrl = acc && pwrite && paddr == `WDT_OFS_CTRL;
  assign wr_status = acc && pwrite && paddr == `WDT_OFS_STATUS;
  assign wr_rstctrl = acc && pwrite && paddr == `WDT_OFS_RSTCTRL;
  assign wr_mode = acc && pwrite && paddr == `WDT_OFS_MODE;
  // unmapped offsets answer with pslverr
  always_comb begin
    rd_err = 1'b0;
    case (paddr)
      `WDT_OFS_REFRESH: rdata_nxt = 32'h0000_00FF;
      `WDT_OFS_CTRL: rdata_nxt = ctrl_in;
      `WDT_OFS_STATUS: rdata_nxt = status_in;
      `WDT_OFS_RSTCTRL: rdata_nxt = rc_in;
      `WDT_OFS_MODE: rdata_nxt = mode_in;
      default: begin
        rdata_nxt = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> hdl/wdt_top.sv
// windowed watchdog: apb registers, 14-bit down-counter, window check, reset/nmi/irq
`timescale 1ns/1ns
`default_nettype none
`include "wdt_regs.svh"
// Functional notes
// R1 - count clock is pclk divided by 4, 64, 128, 512, 2048 or 8192
// R2 - one channel, 14-bit down-counter, minus one per count clock
// R3 - auto-start mode counts right after reset release; here reset clears the mode register, so auto start waits for a mode write
// R4 - register-start mode starts on refresh: write 00h then FFh
// R5 - reset stops counter and restores counter and all registers
// R6 - counting halts while chip is in low power state; here only while mode bit 1 is clear, with it set the counter keeps counting
// R7 - register-start mode stops counter on underflow or refresh error
// R8 - window start and end positions set permitted refresh interval
// R9 - watchdog reset on underflow or out-of-window refresh
// R10 - alternatively nmi or interrupt request on underflow or refresh error
// R11 - status register shows current down-counter value
// R12 - valid refresh reloads timeout; only 00h directly followed by FFh refreshes
// R13 - reset-control setting chooses reset or interrupt
module wdt_top #(
  parameter int CNT_W = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_power,
  output logic wdt_reset_req,
  output logic wdt_nmi_req,
  output logic wdt_irq_req
);
  initial begin
    if (CNT_W != 14) $error("counter width must be 14");
  end
  // ****************************************************
  // registers and bus
  // ****************************************************
  logic [31:0] ctrl_r;
  logic [31:0] rc_r;
  logic [31:0] mode_r;
  logic [CNT_W-1:0] cnt_r;
  logic undf_r;
  logic refe_r;
  logic armed_r;
  wdt_pkg::wdt_state_t state_r;
  logic [31:0] rdata_nxt;
  logic wr_refresh, wr_ctrl, wr_rstctrl, wr_mode, wr_status, rd_err;
  logic [31:0] status;
  wdt_tick_if tk ();
  // status: counter value, sticky flags, running [R11]
  assign status = {15'h0000, state_r == wdt_pkg::ST_RUN, refe_r, undf_r, cnt_r};
  wdt_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .status_in(status),
    .rdata_nxt(rdata_nxt),
    .wr_refresh(wr_refresh),
    .wr_ctrl(wr_ctrl),
    .wr_rstctrl(wr_rstctrl),
    .wr_mode(wr_mode),
    .wr_status(wr_status),
    .rd_err(rd_err),
    .ctrl_in(ctrl_r),
    .rc_in(rc_r),
    .mode_in(mode_r)
  );
  // registered answer: pready rises on the edge that ends the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && rd_err;
      if (psel && !penable && !pwrite) begin
        prdata <= rdata_nxt;
      end
    end
  end
  logic wr_take;
  assign wr_take = pready && penable && psel;
  logic [1:0] to_sel, ws_sel, we_sel;
  assign to_sel = ctrl_r[`WDT_CTRL_TO_LSB +: 2];
  assign ws_sel = ctrl_r[`WDT_CTRL_WSTART_LSB +: 2];
  assign we_sel = ctrl_r[`WDT_CTRL_WEND_LSB +: 2];
  assign tk.sel = ctrl_r[`WDT_CTRL_CKS_LSB +: 3];
  // timeout: 1024, 4096, 8192, 16384 counts
  function automatic logic [CNT_W-1:0] timeout_top(input logic [1:0] s);
    case (s)
      2'h0: timeout_top = 14'h03FF;
      2'h1: timeout_top = 14'h0FFF;
      2'h2: timeout_top = 14'h1FFF;
      default: timeout_top = 14'h3FFF;
    endcase
  endfunction
  // window position: 75, 50, 25, 0 percent of the top remaining
  function automatic logic [CNT_W-1:0] win_pos(input logic [1:0] s, input logic [CNT_W-1:0] t);
    case (s)
      2'h0: win_pos = t - (t >> 2);
      2'h1: win_pos = t >> 1;
      2'h2: win_pos = t >> 2;
      default: win_pos = 14'h0000;
    endcase
  endfunction
  // config registers; written only on the completing access [R5]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `WDT_CTRL_RESET;
      rc_r <= `WDT_RC_RESET;
      mode_r <= `WDT_MODE_RESET;
    end else begin
      if (wr_ctrl && wr_take) begin
        ctrl_r <= pwdata & 32'h0000_3373;
      end
      if (wr_rstctrl && wr_take) begin
        rc_r <= pwdata & 32'h0000_0081; // reset or interrupt select [R13]
      end
      if (wr_mode && wr_take) begin
        mode_r <= pwdata & 32'h0000_0003;
      end
    end
  end
  // ****************************************************
  // refresh sequence and window
  // ****************************************************
  logic rf_wr, rf_first, rf_second, refresh_ok, in_window, refresh_err;
  assign rf_wr = wr_refresh && wr_take;
  assign rf_first = rf_wr && pwdata[7:0] == `WDT_RF_FIRST;
  assign rf_second = rf_wr && pwdata[7:0] == `WDT_RF_SECOND;
  // any refresh-register write other than 00h between 00h and FFh breaks the pair [R4] [R12]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
    end else if (rf_wr) begin
      armed_r <= rf_first;
    end
  end
  // refresh allowed only while window end < count <= window start [R8]
  assign in_window = cnt_r <= win_pos(ws_sel, timeout_top(to_sel))
                  && cnt_r > win_pos(we_sel, timeout_top(to_sel));
  assign refresh_ok = rf_second && armed_r;
  assign refresh_err = refresh_ok && state_r == wdt_pkg::ST_RUN && !in_window;
  logic underflow, halt;
  assign halt = low_power && !mode_r[`WDT_MODE_LPEN_BIT]; // [R6]
  assign underflow = state_r == wdt_pkg::ST_RUN && tk.tick && !halt && cnt_r == '0;
  assign tk.clear = refresh_ok || halt;
  wdt_prescaler #(.DIV_W(13)) u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk)
  );
  // ****************************************************
  // counter and state
  // ****************************************************
  logic auto_start;
  assign auto_start = mode_r[`WDT_MODE_AUTO_BIT];
  // counter: reload on valid refresh, decrement on tick [R2] [R12]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= wdt_pkg::ST_IDLE;
      cnt_r <= 14'h3FFF;
    end else begin
      case (state_r)
        wdt_pkg::ST_IDLE: begin
          cnt_r <= timeout_top(to_sel);
          if (auto_start || refresh_ok) begin
            state_r <= wdt_pkg::ST_RUN; // [R3] [R4]
          end
        end
        wdt_pkg::ST_RUN: begin
          if ((refresh_err || underflow) && !auto_start) begin
            state_r <= wdt_pkg::ST_STOP; // [R7]
          end else if (refresh_ok || underflow) begin
            cnt_r <= timeout_top(to_sel); // [R12]
          end else if (tk.tick && !halt) begin
            cnt_r <= cnt_r - 14'h0001; // [R2]
          end
        end
        wdt_pkg::ST_STOP: begin
          state_r <= wdt_pkg::ST_STOP;
        end
        default: begin
          state_r <= wdt_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // sticky flags; hardware set wins over a software zero write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      undf_r <= 1'b0;
      refe_r <= 1'b0;
    end else begin
      undf_r <= underflow || (undf_r && !(wr_status && wr_take && !pwdata[`WDT_ST_UNDF_BIT]));
      refe_r <= refresh_err || (refe_r && !(wr_status && wr_take && !pwdata[`WDT_ST_REFE_BIT]));
    end
  end
  // event outputs: one-cycle pulses steered by reset control [R9] [R10] [R13]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_reset_req <= 1'b0;
      wdt_nmi_req <= 1'b0;
      wdt_irq_req <= 1'b0;
    end else begin
      wdt_reset_req <= (underflow || refresh_err) && rc_r[`WDT_RC_RSTE_BIT];
      wdt_nmi_req <= (underflow || refresh_err) && !rc_r[`WDT_RC_RSTE_BIT]
                     && rc_r[`WDT_RC_NMI_BIT];
      wdt_irq_req <= (underflow || refresh_err) && !rc_r[`WDT_RC_RSTE_BIT]
                     && !rc_r[`WDT_RC_NMI_BIT];
    end
  end
  // ****************************************************
  // assertions
  // ****************************************************
  a_reset_on_event: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    (underflow || refresh_err) && rc_r[`WDT_RC_RSTE_BIT] |=> wdt_reset_req)
    else $error("watchdog reset missing");
  a_irq_on_event: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    (underflow || refresh_err) && !rc_r[`WDT_RC_RSTE_BIT] |=> (wdt_nmi_req || wdt_irq_req))
    else $error("interrupt missing");
  a_choice_excl: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    !(wdt_reset_req && (wdt_nmi_req || wdt_irq_req)))
    else $error("reset and interrupt together");
  a_refresh_reload: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    refresh_ok && !refresh_err && !underflow && state_r == wdt_pkg::ST_RUN
    |=> cnt_r == $past(timeout_top(to_sel)))
    else $error("refresh did not reload");
  a_halt_holds: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    halt && state_r == wdt_pkg::ST_RUN && !refresh_ok |=> $stable(cnt_r))
    else $error("counter moved in low power");
  a_decrement: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    state_r == wdt_pkg::ST_RUN && tk.tick && !halt && cnt_r != '0 && !refresh_ok
    |=> cnt_r == $past(cnt_r) - 14'h0001)
    else $error("counter did not decrement");
  a_reg_stop: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    !auto_start && state_r == wdt_pkg::ST_RUN && underflow |=> state_r == wdt_pkg::ST_STOP [*2])
    else $error("counter did not stop");
  a_auto_start: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    state_r == wdt_pkg::ST_IDLE && auto_start |=> state_r == wdt_pkg::ST_RUN)
    else $error("auto start failed");
  a_broken_pair: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    state_r == wdt_pkg::ST_IDLE && !auto_start && rf_second && !armed_r
    |=> state_r == wdt_pkg::ST_IDLE)
    else $error("lone FFh started counter");
endmodule
`default_nettype wire

// >>> verification/windowed_watchdog_timer_bench.sv
// self-checking bench for the windowed watchdog timer
`timescale 1ns/1ns
`default_nettype none
`include "wdt_regs.svh"
module windowed_watchdog_timer_bench;
  // ********************************************
  // signals, design instance, clock
  // ********************************************
  logic pclk, presetn, psel, penable, pwrite, low_power;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, s1, s2, s3, s4;
  logic pready, pslverr, err, wdt_reset_req, wdt_nmi_req, wdt_irq_req;
  int errors, check_count, d;
  typedef struct {logic [11:0] addr; logic [31:0] mask; logic [31:0] exp; logic err;} row_t;
  row_t rows [6];

  wdt_top u_wdt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_power(low_power), .wdt_reset_req(wdt_reset_req),
    .wdt_nmi_req(wdt_nmi_req), .wdt_irq_req(wdt_irq_req));

  // free-running 20 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ********************************************
  // shared tasks
  // ********************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; the request is held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat,
                     output logic [31:0] rdat, output logic perr);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("MISMATCH pready expected 1 seen timeout");
      end_of_test();
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat, rd, err);
  endtask

  task automatic rd_status(output logic [31:0] s);
    apb(1'b0, `WDT_OFS_STATUS, 32'h0000_0000, s, err);
  endtask

  task automatic refresh_pair();
    wr(`WDT_OFS_REFRESH, 32'h0000_0000);
    wr(`WDT_OFS_REFRESH, 32'h0000_00FF);
  endtask

  // pulses stand one cycle, so look just after every edge
  task automatic wait_req(input logic [2:0] exp, input int limit);
    logic [2:0] seen;
    seen = 3'b000;
    for (int i = 0; i < limit; i++) begin
      #1;
      seen = {wdt_reset_req, wdt_nmi_req, wdt_irq_req};
      if (seen !== 3'b000) break;
      @(posedge pclk);
    end
    if (seen === 3'b000) begin
      errors++;
      $display("MISMATCH request expected %b seen timeout", exp);
      end_of_test();
    end
    check("request kind", {29'h0, seen}, {29'h0, exp});
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    low_power <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic run_rows();
    foreach (rows[i]) begin
      apb(1'b0, rows[i].addr, 32'h0000_0000, rd, err);
      check("read data", rd & rows[i].mask, rows[i].exp);
      check("slave error", {31'h0, err}, {31'h0, rows[i].err});
    end
  endtask

  // ********************************************
  // main sequence
  // ********************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    low_power = 1'b0;
    errors = 0;
    check_count = 0;
    rows = '{'{`WDT_OFS_REFRESH, 32'h0000_00FF, 32'h0000_00FF, 1'b0},
             '{`WDT_OFS_CTRL, 32'hFFFF_FFFF, `WDT_CTRL_RESET, 1'b0},
             '{`WDT_OFS_STATUS, 32'h0001_FFFF, 32'h0000_3FFF, 1'b0},
             '{`WDT_OFS_RSTCTRL, 32'hFFFF_FFFF, `WDT_RC_RESET, 1'b0},
             '{`WDT_OFS_MODE, 32'hFFFF_FFFF, `WDT_MODE_RESET, 1'b0},
             '{12'h014, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    run_rows();
    $display("test register defaults done");
    // a foreign byte between 00h and FFh must not start the count
    wr(`WDT_OFS_CTRL, 32'h0000_3300);
    wr(`WDT_OFS_REFRESH, 32'h0000_0000);
    wr(`WDT_OFS_REFRESH, 32'h0000_0055);
    wr(`WDT_OFS_REFRESH, 32'h0000_00FF);
    repeat (20) @(posedge pclk);
    rd_status(s1);
    check("running after broken pair", {31'h0, s1[16]}, 32'h0);
    check("counter idle", {18'h0, s1[13:0]}, 32'h0000_03FF);
    refresh_pair();
    rd_status(s1);
    check("running after refresh", {31'h0, s1[16]}, 32'h1);
    $display("test refresh pairing done");
    // freeze in low power, then count at pclk/4
    @(posedge pclk);
    low_power <= 1'b1;
    rd_status(s2);
    repeat (100) @(posedge pclk);
    rd_status(s3);
    check("frozen counter", {18'h0, s3[13:0]}, {18'h0, s2[13:0]});
    @(posedge pclk);
    low_power <= 1'b0;
    repeat (100) @(posedge pclk);
    rd_status(s4);
    d = int'(s3[13:0]) - int'(s4[13:0]);
    check("counter step", {31'h0, d >= 24 && d <= 28}, 32'h1);
    $display("test low power and divider done");
    wait_req(3'b100, 6000);
    rd_status(s1);
    check("underflow flag", {31'h0, s1[14]}, 32'h1);
    check("stopped after underflow", {31'h0, s1[16]}, 32'h0);
    wr(`WDT_OFS_STATUS, 32'h0000_0000);
    rd_status(s1);
    check("underflow flag cleared", {31'h0, s1[14]}, 32'h0);
    $display("test underflow reset done");
    do_reset();
    wr(`WDT_OFS_RSTCTRL, 32'h0000_0000);
    wr(`WDT_OFS_CTRL, 32'h0000_3300);
    refresh_pair();
    wait_req(3'b001, 6000);
    $display("test underflow interrupt done");
    // second refresh at the top of the count falls before the window opens
    do_reset();
    wr(`WDT_OFS_RSTCTRL, 32'h0000_0001);
    wr(`WDT_OFS_CTRL, 32'h0000_0300);
    refresh_pair();
    refresh_pair();
    wait_req(3'b010, 50);
    rd_status(s1);
    check("refresh error flag", {31'h0, s1[15]}, 32'h1);
    check("stopped after error", {31'h0, s1[16]}, 32'h0);
    $display("test refresh error done");
    // refresh inside the window reloads; one after the window end is an error
    do_reset();
    wr(`WDT_OFS_CTRL, 32'h0000_0100);
    refresh_pair();
    repeat (1500) @(posedge pclk);
    refresh_pair();
    rd_status(s1);
    check("reload in window", {18'h0, s1[13:0]}, 32'h0000_03FF);
    check("no error in window", {31'h0, s1[15]}, 32'h0);
    repeat (2200) @(posedge pclk);
    refresh_pair();
    wait_req(3'b100, 50);
    $display("test window positions done");
    // auto start at pclk/4, still counting in low power with the keep bit set
    do_reset();
    wr(`WDT_OFS_CTRL, 32'h0000_3303);
    @(posedge pclk);
    low_power <= 1'b1;
    wr(`WDT_OFS_MODE, 32'h0000_0003);
    repeat (50) @(posedge pclk);
    rd_status(s1);
    check("auto running", {31'h0, s1[16]}, 32'h1);
    check("auto counting", {31'h0, s1[13:0] < 14'h3FFF}, 32'h1);
    do_reset();
    run_rows();
    $display("test auto start and reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
